// *** verilog/fel_params.svh ***
`ifndef FEL_PARAMS_SVH
`define FEL_PARAMS_SVH
// ============================================================
// Register offsets of the controller
`define FEL_REG_CMD        4'h0
`define FEL_REG_ADDR       4'h4
`define FEL_REG_STAT       4'h8
`define FEL_REG_CTRL       4'hc
// ============================================================
// Register reset values
`define FEL_CTRL_RST       1'b0
`define FEL_ADDR_RST       32'h0000_0000
// ============================================================
// Status register field positions
`define FEL_STAT_ERR_LSB   8
`define FEL_STAT_BUSY      16
`define FEL_STAT_DONE      17
`define FEL_STAT_RB        18
// ============================================================
// Flash command codes
`define FEL_CODE_RDSTAT    8'h70
`define FEL_CODE_ERASE     8'h20
`define FEL_CODE_CHIP      8'h30
`define FEL_CODE_CONFIRM   8'hd0
`define FEL_CODE_LOCKSETUP 8'h60
`define FEL_CODE_LOCKBLK   8'h01
`define FEL_CODE_LOCKPERM  8'hf1
`define FEL_CODE_ARRAY     8'hff
`define FEL_CODE_CLRSTAT   8'h50
// ============================================================
// Flash status byte bits
`define FEL_SR_READY       7
`define FEL_SR_ERASE_ERR   5
`define FEL_SR_PROG_ERR    4
`define FEL_SR_VOLT        3
`define FEL_SR_PROT        1
`define FEL_SR_MASK        8'hfe
// ============================================================
// AXI responses
`define FEL_RESP_OKAY      2'h0
`define FEL_RESP_SLVERR    2'h2
// ============================================================
// Bus cycle timing
`define FEL_CLK_NS         10
`define FEL_STROBE_NS      70
`define FEL_RECOV_NS       30
`define FEL_STROBE_CYC     ((`FEL_STROBE_NS + `FEL_CLK_NS - 1) / `FEL_CLK_NS)
`define FEL_RECOV_CYC      ((`FEL_RECOV_NS + `FEL_CLK_NS - 1) / `FEL_CLK_NS)
`endif

// *** verilog/fel_pkg.sv ***
`include "fel_params.svh"
package fel_pkg;
    // ============================================================
    // Operations requested by software
    typedef enum logic [2:0] {
        FEL_OP_NONE  = 3'h0, FEL_OP_BLK_ERASE = 3'h1, FEL_OP_CHIP = 3'h2,
        FEL_OP_LOCKB = 3'h3, FEL_OP_LOCKP     = 3'h4, FEL_OP_UNLOCK = 3'h5,
        FEL_OP_CLRST = 3'h6, FEL_OP_ARRAY     = 3'h7
    } fel_op_t;
    // Outcome of the full status check
    typedef enum logic [2:0] {
        FEL_ERR_NONE = 3'h0, FEL_ERR_VOLT = 3'h1, FEL_ERR_PROT = 3'h2,
        FEL_ERR_SEQ  = 3'h3, FEL_ERR_OP   = 3'h4
    } fel_err_t;
    // Sequencer states
    typedef enum logic [10:0] {
        S_IDLE  = 11'h001, S_RS1 = 11'h002, S_P1    = 11'h004,
        S_SETUP = 11'h008, S_CONF = 11'h010, S_RS2  = 11'h020,
        S_P2    = 11'h040, S_CHECK = 11'h080, S_CLR = 11'h100,
        S_ARRAY = 11'h200, S_SPARE = 11'h400
    } fel_state_t;
    // Bus cycle phases
    typedef enum logic [3:0] {
        PH_IDLE = 4'h1, PH_SETUP = 4'h2, PH_STROBE = 4'h4, PH_RECOV = 4'h8
    } fel_phase_t;

    // ============================================================
    // Full status check in fixed order, reserved bit masked
    function automatic fel_err_t fel_full_check(input logic [7:0] sr,
                                                input fel_op_t    op);
        logic [7:0] m;
        m = sr & `FEL_SR_MASK;
        if (m[`FEL_SR_VOLT])
            return FEL_ERR_VOLT;
        if (m[`FEL_SR_PROT])
            return FEL_ERR_PROT;
        if (m[`FEL_SR_ERASE_ERR] && m[`FEL_SR_PROG_ERR])
            return FEL_ERR_SEQ;
        if (op == FEL_OP_LOCKB || op == FEL_OP_LOCKP)
            return m[`FEL_SR_PROG_ERR] ? FEL_ERR_OP : FEL_ERR_NONE;
        return m[`FEL_SR_ERASE_ERR] ? FEL_ERR_OP : FEL_ERR_NONE;
    endfunction : fel_full_check

    // Setup code of each two-step operation
    function automatic logic [7:0] fel_setup_code(input fel_op_t op);
        case (op)
            FEL_OP_BLK_ERASE: return `FEL_CODE_ERASE;
            FEL_OP_CHIP:      return `FEL_CODE_CHIP;
            default:          return `FEL_CODE_LOCKSETUP;
        endcase
    endfunction : fel_setup_code

    // Confirm code of each two-step operation
    function automatic logic [7:0] fel_confirm_code(input fel_op_t op);
        case (op)
            FEL_OP_LOCKB: return `FEL_CODE_LOCKBLK;
            FEL_OP_LOCKP: return `FEL_CODE_LOCKPERM;
            default:      return `FEL_CODE_CONFIRM;
        endcase
    endfunction : fel_confirm_code
endpackage : fel_pkg

// *** verilog/fel_bus_cycle.sv ***
`timescale 1ns/1ps
`include "fel_params.svh"
module fel_bus_cycle
    import fel_pkg::*;
#(
    parameter int ADDR_W     = 22,
    parameter int STROBE_CYC = `FEL_STROBE_CYC,
    parameter int RECOV_CYC  = `FEL_RECOV_CYC
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Cycle request
    input  wire logic              go,
    input  wire logic              go_wr,
    input  wire logic [ADDR_W-1:0] go_addr,
    input  wire logic [7:0]        go_data,
    output logic                   done,
    output logic [7:0]             rdata,
    // Flash pins
    output logic [ADDR_W-1:0]      flash_addr,
    output logic                   flash_ce_n,
    output logic                   flash_we_n,
    output logic                   flash_oe_n,
    output logic [7:0]             flash_dq_o,
    output logic                   flash_dq_oe,
    input  wire logic [7:0]        flash_dq_i
);
    fel_phase_t ph_q;
    logic       wr_q;
    logic [7:0] cnt_q;
    logic [7:0] dq_s1_q;
    logic [7:0] dq_s2_q;

    // ============================================================
    // Data pin synchroniser
    always_ff @(posedge clk) begin
        dq_s1_q <= flash_dq_i;
        dq_s2_q <= dq_s1_q;
    end

    // ============================================================
    // One asynchronous write or read cycle on the flash pins
    always_ff @(posedge clk) begin
        if (rst) begin
            ph_q        <= PH_IDLE;
            wr_q        <= 1'b0;
            cnt_q       <= 8'h00;
            done        <= 1'b0;
            rdata       <= 8'h00;
            flash_addr  <= '0;
            flash_ce_n  <= 1'b1;
            flash_we_n  <= 1'b1;
            flash_oe_n  <= 1'b1;
            flash_dq_o  <= 8'h00;
            flash_dq_oe <= 1'b0;
        end else begin
            done <= 1'b0;
            case (ph_q)
                PH_IDLE: begin
                    if (go) begin
                        flash_addr  <= go_addr;
                        flash_dq_o  <= go_data;
                        flash_dq_oe <= go_wr;
                        wr_q        <= go_wr;
                        flash_ce_n  <= 1'b0;
                        ph_q        <= PH_SETUP;
                    end
                end
                PH_SETUP: begin
                    flash_we_n <= ~wr_q;
                    flash_oe_n <= wr_q;
                    cnt_q      <= 8'(STROBE_CYC - 1);
                    ph_q       <= PH_STROBE;
                end
                PH_STROBE: begin
                    if (cnt_q == 8'h00) begin
                        flash_we_n <= 1'b1;
                        flash_oe_n <= 1'b1;
                        flash_ce_n <= 1'b1;
                        if (!wr_q)
                            rdata <= dq_s2_q; // Synchronised read data
                        cnt_q <= 8'(RECOV_CYC - 1);
                        ph_q  <= PH_RECOV;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                PH_RECOV: begin
                    if (cnt_q == 8'h00) begin
                        flash_dq_oe <= 1'b0; // Data held past strobe
                        done        <= 1'b1;
                        ph_q        <= PH_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: ph_q <= PH_IDLE;
            endcase
        end
    end
endmodule : fel_bus_cycle

// *** verilog/fel_ctrl.sv ***
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "fel_params.svh"
// Functional notes
// RL1: Device status bit 1 reports an operation refused by a lock.
// RL2: Device judges protection only by locks relevant to the operation.
// RL3: Reserved status bit 0 is masked from every status comparison.
// RL4: Device write-suspend bit is 1 only while a write is suspended.
// RL5: Identifier reads return current block and permanent lock states.
// RL6: Block erase writes 20H, then D0H inside the block, then polls.
// RL7: Block erases may follow back to back, each fully checked.
// RL8: After the final operation write FFH to return to read array.
// RL9: Check voltage bit, protection bit, sequence error, then own error.
// RL10: Device error bits stay set until the clear-status command.
// RL11: On any error issue clear-status before anything else.
// RL12: Chip erase writes 30H then D0H; failure shows in bit 5.
// RL13: Device flags protection during chip erase when all blocks locked.
// RL14: Lock set writes 60H then 01H at block or F1H for permanent.
// RL15: Device refuses block lock set when permanent lock is set.
// RL16: Clearing all locks writes 60H then D0H; failure in bit 5.
// RL17: Device refuses lock clearing when permanent lock is set.
// RL18: Read status and poll bit 7 ready before and after each sequence.
// RL19: Device ready/busy goes low on a command, high when done.
// RL20: Device sets voltage error bit with bit 4 or bit 5.
// RL21: Device clears status on power-off or reset pin low.
// RL22: Device enters read-array mode at power-up and after reset.
module fel_ctrl
    import fel_pkg::*;
#(
    parameter int ADDR_W     = 22,
    parameter int STROBE_CYC = `FEL_STROBE_CYC,
    parameter int RECOV_CYC  = `FEL_RECOV_CYC
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // AXI4-Lite write channels
    input  wire logic [3:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [3:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Flash pins
    output logic [ADDR_W-1:0]      flash_addr,
    output logic                   flash_ce_n,
    output logic                   flash_we_n,
    output logic                   flash_oe_n,
    output logic [7:0]             flash_dq_o,
    output logic                   flash_dq_oe,
    input  wire logic [7:0]        flash_dq_i,
    output logic                   reset_powerdown_pin_n,
    input  wire logic              ready_busy_output
);
    fel_state_t        st_q, st_d;
    fel_op_t           op_q;
    fel_err_t          err_q, err_now;
    logic [ADDR_W-1:0] addr_q;
    logic [7:0]        stat_q, last_wr_q, cyc_data, cyc_rdata;
    logic              hold_q, done_q, issued_q, rb_s1_q, rb_s2_q;
    logic              busy, has_cyc, cyc_go, cyc_wr, cyc_done;
    logic              wr_fire, cmd_fire, wr_bad;

    // Known register offsets
    function automatic logic reg_hit(input logic [3:0] a);
        return a == `FEL_REG_CMD || a == `FEL_REG_ADDR ||
               a == `FEL_REG_STAT || a == `FEL_REG_CTRL;
    endfunction : reg_hit

    // ============================================================
    // AXI write channels: address and data taken together
    assign wr_fire  = s_axi_awready;
    assign busy     = st_q != S_IDLE;
    assign cmd_fire = wr_fire && s_axi_awaddr == `FEL_REG_CMD && !busy &&
                      !hold_q && s_axi_wstrb[0];
    assign wr_bad   = !reg_hit(s_axi_awaddr) ||
                      s_axi_awaddr == `FEL_REG_STAT ||
                      (s_axi_awaddr == `FEL_REG_CMD && !cmd_fire);

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `FEL_RESP_OKAY;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_bad ? `FEL_RESP_SLVERR : `FEL_RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Software registers
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_q <= ADDR_W'(`FEL_ADDR_RST);
            hold_q <= `FEL_CTRL_RST;
        end else if (wr_fire && s_axi_wstrb[0]) begin
            if (s_axi_awaddr == `FEL_REG_ADDR)
                addr_q <= ADDR_W'(s_axi_wdata);
            if (s_axi_awaddr == `FEL_REG_CTRL)
                hold_q <= s_axi_wdata[0];
        end
    end

    // ============================================================
    // AXI read channels
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `FEL_RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready &&
                             !s_axi_rvalid;
            if (s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= reg_hit(s_axi_araddr) ?
                                `FEL_RESP_OKAY : `FEL_RESP_SLVERR;
                case (s_axi_araddr)
                    `FEL_REG_CMD:  s_axi_rdata <= {29'h0, op_q};
                    `FEL_REG_ADDR: s_axi_rdata <= 32'(addr_q);
                    `FEL_REG_STAT: s_axi_rdata <= {13'h0, rb_s2_q, done_q,
                                                   busy, 5'h0, err_q, stat_q};
                    `FEL_REG_CTRL: s_axi_rdata <= {31'h0, hold_q};
                    default:       s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ============================================================
    // Reset pin drive and ready/busy synchroniser
    always_ff @(posedge clk) begin
        if (rst)
            reset_powerdown_pin_n <= 1'b0;
        else
            reset_powerdown_pin_n <= ~hold_q;
    end

    always_ff @(posedge clk) begin
        rb_s1_q <= ready_busy_output;
        rb_s2_q <= rb_s1_q;
    end

    // ============================================================
    // Sequencer: next state and the bus cycle each state issues
    assign err_now = fel_full_check(stat_q, op_q); // RL3 RL9
    assign has_cyc = st_q != S_IDLE && st_q != S_CHECK;
    assign cyc_go  = has_cyc && !issued_q;

    always_comb begin
        st_d     = st_q;
        cyc_wr   = 1'b1;
        cyc_data = `FEL_CODE_RDSTAT;
        case (st_q)
            S_IDLE: begin
                if (cmd_fire) begin
                    case (fel_op_t'(s_axi_wdata[2:0]))
                        FEL_OP_NONE:  st_d = S_IDLE;
                        FEL_OP_CLRST: st_d = S_CLR;
                        FEL_OP_ARRAY: st_d = S_ARRAY;
                        default:      st_d = S_RS1;
                    endcase
                end
            end
            S_RS1:   if (cyc_done) st_d = S_P1;
            S_P1: begin
                cyc_wr = 1'b0;
                if (cyc_done && cyc_rdata[`FEL_SR_READY])
                    st_d = S_SETUP; // RL18
            end
            S_SETUP: begin
                cyc_data = fel_setup_code(op_q); // RL6 RL12 RL14 RL16
                if (cyc_done) st_d = S_CONF;
            end
            S_CONF: begin
                cyc_data = fel_confirm_code(op_q); // RL6 RL12 RL14 RL16
                if (cyc_done) st_d = S_RS2;
            end
            S_RS2:   if (cyc_done) st_d = S_P2; // RL18
            S_P2: begin
                cyc_wr = 1'b0;
                if (cyc_done && cyc_rdata[`FEL_SR_READY])
                    st_d = S_CHECK; // RL18
            end
            S_CHECK: st_d = err_now != FEL_ERR_NONE ? S_CLR : S_ARRAY; // RL11
            S_CLR: begin
                cyc_data = `FEL_CODE_CLRSTAT; // RL11
                if (cyc_done) st_d = S_ARRAY;
            end
            S_ARRAY: begin
                cyc_data = `FEL_CODE_ARRAY; // RL8
                if (cyc_done) st_d = S_IDLE; // RL7
            end
            default: st_d = S_IDLE;
        endcase
    end

    // State, issue flag and written-code record
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q      <= S_IDLE;
            issued_q  <= 1'b0;
            last_wr_q <= 8'h00;
        end else begin
            st_q     <= st_d;
            issued_q <= cyc_done ? 1'b0 : (issued_q | cyc_go);
            if (cyc_go && cyc_wr)
                last_wr_q <= cyc_data;
        end
    end

    // Operation, status byte, check result and done flag
    always_ff @(posedge clk) begin
        if (rst) begin
            op_q   <= FEL_OP_NONE;
            stat_q <= 8'h00;
            err_q  <= FEL_ERR_NONE;
            done_q <= 1'b0;
        end else begin
            if (cmd_fire) begin
                op_q  <= fel_op_t'(s_axi_wdata[2:0]);
                err_q <= FEL_ERR_NONE;
            end
            if (cyc_done && !cyc_wr)
                stat_q <= cyc_rdata;
            if (st_q == S_CHECK)
                err_q <= err_now; // RL9
            if (st_q == S_ARRAY && cyc_done)
                done_q <= 1'b1;
            else if (cmd_fire)
                done_q <= 1'b0;
        end
    end

    // ============================================================
    // Flash bus cycle engine
    fel_bus_cycle #(
        .ADDR_W     (ADDR_W),
        .STROBE_CYC (STROBE_CYC),
        .RECOV_CYC  (RECOV_CYC)
    ) u_cycle (
        .clk         (clk),
        .rst         (rst),
        .go          (cyc_go),
        .go_wr       (cyc_wr),
        .go_addr     (addr_q),
        .go_data     (cyc_data),
        .done        (cyc_done),
        .rdata       (cyc_rdata),
        .flash_addr  (flash_addr),
        .flash_ce_n  (flash_ce_n),
        .flash_we_n  (flash_we_n),
        .flash_oe_n  (flash_oe_n),
        .flash_dq_o  (flash_dq_o),
        .flash_dq_oe (flash_dq_oe),
        .flash_dq_i  (flash_dq_i)
    );

    // ============================================================
    // Assertions and covers
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_RSVD_MASK: assert property ( // RL3
        st_q == S_CHECK |->
        err_now == fel_full_check(stat_q ^ 8'h01, op_q))
        else $error("reserved status bit changed the check");
    AST_ERR_ORDER: assert property ( // RL9
        (st_q == S_CHECK && stat_q[`FEL_SR_VOLT]) |=> err_q == FEL_ERR_VOLT)
        else $error("voltage error not reported first");
    AST_ERASE_SEQ: assert property ( // RL6
        (cyc_go && st_q == S_CONF && op_q == FEL_OP_BLK_ERASE) |->
        (last_wr_q == `FEL_CODE_ERASE && cyc_data == `FEL_CODE_CONFIRM))
        else $error("block erase sequence wrong");
    AST_CHIP_SEQ: assert property ( // RL12
        (cyc_go && st_q == S_CONF && op_q == FEL_OP_CHIP) |->
        (last_wr_q == `FEL_CODE_CHIP && cyc_data == `FEL_CODE_CONFIRM))
        else $error("chip erase sequence wrong");
    AST_LOCK_SEQ: assert property ( // RL14
        (cyc_go && st_q == S_CONF && op_q == FEL_OP_LOCKP) |->
        (last_wr_q == `FEL_CODE_LOCKSETUP && cyc_data == `FEL_CODE_LOCKPERM))
        else $error("permanent lock sequence wrong");
    AST_UNLOCK_SEQ: assert property ( // RL16
        (cyc_go && st_q == S_CONF && op_q == FEL_OP_UNLOCK) |->
        (last_wr_q == `FEL_CODE_LOCKSETUP && cyc_data == `FEL_CODE_CONFIRM))
        else $error("lock clearing sequence wrong");
    AST_POLL_READY: assert property ( // RL18
        (st_q == S_P2 && cyc_done && !cyc_rdata[`FEL_SR_READY]) |=>
        (st_q == S_P2 && cyc_go && !cyc_wr))
        else $error("status not polled again while busy");
    AST_CLR_ON_ERR: assert property ( // RL11
        (st_q == S_CHECK && err_now != FEL_ERR_NONE) |=>
        (st_q == S_CLR && cyc_go && cyc_data == `FEL_CODE_CLRSTAT))
        else $error("clear-status not issued after error");
    AST_END_ARRAY: assert property ( // RL8
        (st_q == S_ARRAY && cyc_done) |->
        last_wr_q == `FEL_CODE_ARRAY ##1 (st_q == S_IDLE && done_q))
        else $error("read array not restored at end");

    COV_ERASE_OK: cover property (st_q == S_CHECK &&
        op_q == FEL_OP_BLK_ERASE && err_now == FEL_ERR_NONE);
    COV_CHIP_ERR: cover property (
        st_q == S_CHECK && op_q == FEL_OP_CHIP && err_now != FEL_ERR_NONE);
    COV_LOCK_BLK: cover property (
        st_q == S_CONF && op_q == FEL_OP_LOCKB && cyc_go);
endmodule : fel_ctrl

// *** tb/fel_flash_model.sv ***
`timescale 1ns/1ps
// ============================================================
// Flash device model, two lock blocks chosen by address bit 21
module fel_flash_model #(parameter int BUSY_NS = 2000) (
    // Bus pins and voltage-low knob
    input  wire logic        rst_pin_n,
    input  wire logic        ce_n,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic        vlow,
    input  wire logic [21:0] addr,
    input  wire logic [7:0]  din,
    // Read data and ready, driven low while busy and high otherwise
    output logic [7:0]       dout,
    output logic             rdy
);
    logic [7:0] st = 8'h00, cmd = 8'h00, v;
    logic [1:0] lk = 2'h0;
    logic       perm = 1'b0, stm = 1'b0, busy = 1'b0, pf;
    event       go;
    // Released bus shows the inverse; bit 0 reads one, bit 2 stays 0
    assign v    = stm ? {~busy, st[6:1], 1'b1} : 8'hff;
    assign dout = (!ce_n && !oe_n) ? v : ~v;
    assign rdy  = ~busy;
    // Busy window of the internal algorithm
    always @(go) begin
        busy = 1'b1;
        #(BUSY_NS) busy = 1'b0;
    end
    // Commands taken while selected; error bits accumulate until 50H or reset
    always @(negedge we_n or negedge rst_pin_n) begin
        if (!rst_pin_n) begin
            st  = 8'h00;
            stm = 1'b0;
            cmd = 8'h00;
        end else if (!ce_n && cmd != 8'h00) begin
            case ({cmd, din})
                16'h20d0: pf = lk[addr[21]];
                16'h30d0: pf = &lk;
                16'h60f1: pf = 1'b0;
                default:  pf = perm;
            endcase
            if (vlow)
                st = st | (din[0] ? 8'h18 : 8'h28);
            else if (pf)
                st[1] = 1'b1;
            else if (din == 8'hf1)
                perm = 1'b1;
            else if (din == 8'h01)
                lk[addr[21]] = 1'b1;
            else if (cmd == 8'h60)
                lk = 2'h0;
            cmd = 8'h00;
            -> go;
        end else if (!ce_n) begin
            stm = din != 8'hff;
            if (din == 8'h50)
                st = 8'h00;
            if (din inside {8'h20, 8'h30, 8'h60})
                cmd = din;
        end
    end
endmodule : fel_flash_model

// *** tb/test_flash_erase_lock_command_flows.sv ***
`timescale 1ns/1ps
`include "fel_params.svh"
// ============================================================
// Control reset read first, then the operation table, refusals and the hold pin
module test_flash_erase_lock_command_flows;
    typedef struct packed {
        logic [2:0] op;
        logic       blk, vl;
        logic [2:0] res;
        logic [7:0] st;
    } fel_row_t;
    logic        clk = 1'b0, rst = 1'b1, vlow = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [21:0] flash_addr;
    logic [7:0]  flash_dq_o, flash_dq_i, m_dq;
    logic        flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe;
    logic        reset_powerdown_pin_n, ready_busy_output;
    int          num_errors = 0, n_compared = 0;
    fel_row_t    r;
    fel_row_t    rows [13] = '{
        '{3'h1,1'h0,1'h0,3'h0,8'h81}, '{3'h3,1'h0,1'h0,3'h0,8'h81},
        '{3'h1,1'h0,1'h0,3'h2,8'h83}, '{3'h1,1'h1,1'h0,3'h0,8'h81},
        '{3'h3,1'h1,1'h0,3'h0,8'h81}, '{3'h2,1'h0,1'h0,3'h2,8'h83},
        '{3'h5,1'h0,1'h0,3'h0,8'h81}, '{3'h1,1'h1,1'h1,3'h1,8'ha9},
        '{3'h4,1'h0,1'h0,3'h0,8'h81}, '{3'h3,1'h0,1'h0,3'h2,8'h83},
        '{3'h5,1'h0,1'h0,3'h2,8'h83}, '{3'h6,1'h0,1'h0,3'h0,8'h83},
        '{3'h7,1'h0,1'h0,3'h0,8'h83}};
    // Clock, shared data wire and the two parties
    always #5 clk = ~clk;
    assign flash_dq_i = flash_dq_oe ? flash_dq_o : m_dq;
    fel_ctrl #(.STROBE_CYC(3), .RECOV_CYC(1)) u_dut (.*);
    fel_flash_model u_flash (.rst_pin_n(reset_powerdown_pin_n),
        .ce_n(flash_ce_n), .we_n(flash_we_n), .oe_n(flash_oe_n),
        .vlow(vlow), .addr(flash_addr), .din(flash_dq_i), .dout(m_dq),
        .rdy(ready_busy_output));
    task automatic chk(input logic [31:0] seen, exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One register access; each channel released once taken
    task automatic axi(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_araddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid  <= wr;
        s_axi_arvalid <= !wr;
        s_axi_bready  <= wr;
        s_axi_rready  <= !wr;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(wr ? s_axi_bvalid : s_axi_rvalid));
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        rs = wr ? s_axi_bresp : s_axi_rresp;
        rd = s_axi_rdata;
    endtask : axi
    task automatic poll();
        do axi(1'b0, `FEL_REG_STAT, 32'h0);
        while (rd[16] || !rd[17]);
    endtask : poll
    task automatic final_report();
        $display("errors %0d of %0d checks", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    initial begin
        #500000;
        num_errors++;
        final_report();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        axi(1'b0, `FEL_REG_CTRL, 32'h0);
        chk({rd[30:0], rs[1]}, 32'h0, "ctrl reset");
        foreach (rows[i]) begin
            r = rows[i];
            vlow <= r.vl;
            axi(1'b1, `FEL_REG_ADDR, {10'h0, r.blk, 21'h0});
            axi(1'b1, `FEL_REG_CMD, {29'h0, r.op});
            poll();
            chk(rd, {16'h6, 5'h0, r.res, r.st}, "stat");
            chk({31'h0, u_flash.stm}, 32'h0, "array");
        end
        axi(1'b1, `FEL_REG_CMD, 32'h1);
        axi(1'b1, `FEL_REG_CMD, 32'h1);
        chk({30'h0, rs}, 32'h2, "busy cmd");
        poll();
        axi(1'b0, 4'h2, 32'h0);
        chk({rs, rd[29:0]}, 32'h80000000, "unmapped");
        s_axi_wstrb <= 4'h0;
        axi(1'b1, `FEL_REG_CMD, 32'h1);
        chk({30'h0, rs}, 32'h2, "strobe off");
        s_axi_wstrb <= 4'hf;
        axi(1'b1, `FEL_REG_CTRL, 32'h1);
        axi(1'b0, `FEL_REG_CTRL, 32'h0);
        chk({rd[30:0], reset_powerdown_pin_n}, 32'h2, "hold");
        axi(1'b1, `FEL_REG_CTRL, 32'h0);
        final_report();
    end
endmodule : test_flash_erase_lock_command_flows
